// ### design/wor_rc_tick.v
// Purpose: rc-oscillator stand-in, one enable pulse per rc period
// Assumes: clk_i is the crystal clock
// Notes:   held silent while powered down
`timescale 1ns/1ns
`default_nettype none
`include "wor_regs.vh"

module wor_rc_tick #(
	parameter DIV = `WOR_RC_DIV
) (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire run_i,
	output wire tick_o
);
	reg [9:0] cnt_ff;
	wire      last = (cnt_ff == DIV[9:0] - 10'h001);

	always @(posedge clk_i) begin
		if (!rst_n_i || !run_i) begin
			cnt_ff <= 10'h000;
		end else if (last) begin
			cnt_ff <= 10'h000;
		end else begin
			cnt_ff <= cnt_ff + 10'h001;
		end
	end

	assign tick_o = run_i & last;
endmodule
`default_nettype wire

// ### design/wor_timer.v
// Purpose: wake-on-radio event timer with its three config registers
// Assumes: host register port is a plain synchronous strobe interface
// Notes:   rc clock modelled as crystal / 750 enable pulses
// Functional notes
// - 16-bit first-event timeout held in high and low byte registers.
// - timer ticks at crystal/750; timeout is period*count*resolution.
// - timeout bytes reset to 0x87 and 0x6b.
// - power-down bit resets to 1; clearing it powers up and calibrates.
// - second-event code 0..7 gives 4,6,8,12,16,24,32,48 periods; reset 7.
// - bit 3 enables calibration, reset value 1, debug use only.
// - resolution code 0 gives 1 period, 1 gives 32; host avoids 2,3.
`timescale 1ns/1ns
`default_nettype none
`include "wor_regs.vh"

module wor_timer #(
	parameter CAL_CYCLES = `WOR_CAL_CYCLES
) (
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire [5:0] addr_i,
	input  wire       wr_i,
	input  wire [7:0] wdata_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	output reg        rvalid_o,
	output wire       rc_osc_run_o,
	output reg        calibrating_o,
	output reg        first_event_o,
	output reg        second_event_o
);
	// ************************************************************
	// registers
	// ************************************************************
	reg [7:0] evt_high_ff;
	reg [7:0] evt_low_ff;
	reg [7:0] ctrl_ff;

	wire       pd       = ctrl_ff[`WOR_CTRL_PD_BIT];
	wire [2:0] sel      = ctrl_ff[`WOR_CTRL_SEL_HI:`WOR_CTRL_SEL_LO];
	wire       cal_en   = ctrl_ff[`WOR_CTRL_CAL_BIT];
	wire [1:0] res      = ctrl_ff[`WOR_CTRL_RES_HI:`WOR_CTRL_RES_LO];
	wire [15:0] evt0    = {evt_high_ff, evt_low_ff};

	// ************************************************************
	// second-event decode
	// ************************************************************

	function [5:0] second_periods;
		input [2:0] code;
		begin
			case (code)
			3'h0: second_periods = `WOR_EV1_P0;
			3'h1: second_periods = `WOR_EV1_P1;
			3'h2: second_periods = `WOR_EV1_P2;
			3'h3: second_periods = `WOR_EV1_P3;
			3'h4: second_periods = `WOR_EV1_P4;
			3'h5: second_periods = `WOR_EV1_P5;
			3'h6: second_periods = `WOR_EV1_P6;
			default: second_periods = `WOR_EV1_P7;
			endcase
		end
	endfunction

	// ************************************************************
	// register writes
	// ************************************************************

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			evt_high_ff <= `WOR_RST_EVT0_HIGH;
			evt_low_ff  <= `WOR_RST_EVT0_LOW;
			ctrl_ff     <= `WOR_RST_CTRL;
		end else if (wr_i) begin
			case (addr_i)
			`WOR_ADDR_EVT0_HIGH: evt_high_ff <= wdata_i;
			`WOR_ADDR_EVT0_LOW:  evt_low_ff  <= wdata_i;
			`WOR_ADDR_CTRL:      ctrl_ff <= wdata_i & `WOR_CTRL_WR_MASK;
			default: ;
			endcase
		end
	end

	// ************************************************************
	// register reads
	// ************************************************************
	// reads answer next cycle; unmapped addresses read zero
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd_i;
			case (addr_i)
			`WOR_ADDR_EVT0_HIGH: rdata_o <= evt_high_ff;
			`WOR_ADDR_EVT0_LOW:  rdata_o <= evt_low_ff;
			`WOR_ADDR_CTRL:      rdata_o <= ctrl_ff;
			default:             rdata_o <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// rc oscillator
	// ************************************************************
	assign rc_osc_run_o = ~pd;

	wire rc_tick;
	wor_rc_tick #(
		.DIV(`WOR_RC_DIV)
	) u_tick (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.run_i  (rc_osc_run_o),
		.tick_o (rc_tick)
	);

	// ************************************************************
	// calibration
	// ************************************************************

	// calibration starts on the falling edge of power-down
	reg        pd_q_ff;
	reg [15:0] cal_cnt_ff;

	reg        nxt_calibrating;
	reg [15:0] nxt_cal_cnt;

	always @* begin
		nxt_calibrating = calibrating_o;
		nxt_cal_cnt     = cal_cnt_ff;
		if (pd || !cal_en) begin
			nxt_calibrating = 1'b0;
		end else if (pd_q_ff) begin
			nxt_calibrating = 1'b1;
			nxt_cal_cnt     = CAL_CYCLES[15:0];
		end else if (calibrating_o) begin
			if (cal_cnt_ff == 16'h0001) begin
				nxt_calibrating = 1'b0;
			end
			nxt_cal_cnt = cal_cnt_ff - 16'h0001;
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			pd_q_ff       <= 1'b1;
			calibrating_o <= 1'b0;
			cal_cnt_ff    <= 16'h0000;
		end else begin
			pd_q_ff       <= pd;
			calibrating_o <= nxt_calibrating;
			cal_cnt_ff    <= nxt_cal_cnt;
		end
	end

	// ************************************************************
	// event timers, first in resolution units, second in rc periods
	// ************************************************************
	reg [4:0]  pre_ff;
	reg [15:0] ev0_cnt_ff;
	reg [5:0]  ev1_cnt_ff;
	reg        ev1_run_ff;

	reg [4:0]  nxt_pre;
	reg [15:0] nxt_ev0_cnt;
	reg [5:0]  nxt_ev1_cnt;
	reg        nxt_ev1_run;
	reg        nxt_second;
	// codes 2 and 3 are kept off by the host; here they act as code 0
	wire       res32   = (res == `FIRST_EVENT_RESOLUTION_X32);
	wire       unit    = rc_tick & (!res32 | (pre_ff == `WOR_PRE_LAST));
	wire       ev0_hit = unit & (ev0_cnt_ff + 16'h0001 >= evt0);

	// the second countdown runs on rc periods, not on resolution units
	always @* begin
		nxt_pre     = pre_ff;
		nxt_ev0_cnt = ev0_cnt_ff;
		nxt_ev1_cnt = ev1_cnt_ff;
		nxt_ev1_run = ev1_run_ff;
		nxt_second  = 1'b0;
		if (rc_tick) begin
			nxt_pre = res32 ? pre_ff + 5'h01 : 5'h00;
		end
		// >= so that lowering the timeout mid-count expires on the next resolution unit
		if (ev0_hit) begin
			nxt_ev0_cnt = 16'h0000;
		end else if (unit) begin
			nxt_ev0_cnt = ev0_cnt_ff + 16'h0001;
		end
		if (ev0_hit) begin
			nxt_ev1_run = 1'b1;
			nxt_ev1_cnt = second_periods(sel);
		end else if (ev1_run_ff && rc_tick) begin
			if (ev1_cnt_ff == 6'h01) begin
				nxt_ev1_run = 1'b0;
				nxt_second  = 1'b1;
			end
			nxt_ev1_cnt = ev1_cnt_ff - 6'h01;
		end
	end

	// power-down clears all event counters, so a restart begins a full period
	always @(posedge clk_i) begin
		if (!rst_n_i || pd) begin
			pre_ff         <= 5'h00;
			ev0_cnt_ff     <= 16'h0000;
			ev1_cnt_ff     <= 6'h00;
			ev1_run_ff     <= 1'b0;
			first_event_o  <= 1'b0;
			second_event_o <= 1'b0;
		end else begin
			pre_ff         <= nxt_pre;
			ev0_cnt_ff     <= nxt_ev0_cnt;
			ev1_cnt_ff     <= nxt_ev1_cnt;
			ev1_run_ff     <= nxt_ev1_run;
			first_event_o  <= ev0_hit;
			second_event_o <= nxt_second;
		end
	end
endmodule
`default_nettype wire

// ### include/wor_regs.vh
// Purpose: constants for the wake timer register block
// Assumes: 8-bit registers at their printed addresses
// Notes:   included by both design files
`ifndef WOR_TIMER_REGS_VH
`define WOR_TIMER_REGS_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define WOR_ADDR_EVT0_HIGH 6'h1e
`define WOR_ADDR_EVT0_LOW  6'h1f
`define WOR_ADDR_CTRL      6'h20

// ****************************************************************
// reset values
// ****************************************************************
`define WOR_RST_EVT0_HIGH  8'h87
`define WOR_RST_EVT0_LOW   8'h6b
`define WOR_RST_CTRL       8'hf8

// ****************************************************************
// control field positions
// ****************************************************************
`define WOR_CTRL_PD_BIT    7
`define WOR_CTRL_SEL_HI    6
`define WOR_CTRL_SEL_LO    4
`define WOR_CTRL_CAL_BIT   3
`define WOR_CTRL_RES_HI    1
`define WOR_CTRL_RES_LO    0
`define WOR_CTRL_WR_MASK   8'hfb
`define FIRST_EVENT_RESOLUTION_X32        2'h1

// ****************************************************************
// timing
// ****************************************************************
`define WOR_RC_DIV         750
`define FIRST_EVENT_RESOLUTION_SHIFT      5
`define WOR_CAL_CYCLES     16'h0400
`define WOR_PRE_LAST       5'h1f

// ****************************************************************
// second-event lengths in rc periods, by code
// ****************************************************************
`define WOR_EV1_P0         6'h04
`define WOR_EV1_P1         6'h06
`define WOR_EV1_P2         6'h08
`define WOR_EV1_P3         6'h0c
`define WOR_EV1_P4         6'h10
`define WOR_EV1_P5         6'h18
`define WOR_EV1_P6         6'h20
`define WOR_EV1_P7         6'h30

`endif

// ### test/wor_host.sv
// Purpose: host model driving the timer register port
// Assumes: one access at a time, strobes launched on rising edges
// Notes: bit 1 of the control byte is never set
`timescale 1ns/1ns
`default_nettype none
module wor_host (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	output logic      [5:0] addr_o = 6'h00,
	output logic            wr_o = 1'b0,
	output logic      [7:0] wdata_o = 8'h00,
	output logic            rd_o = 1'b0
);
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= (a == 6'h20) ? (d & 8'hfd) : d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// data is only trusted when the valid pulse is up
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rvalid_i ? rdata_i : 8'hxx;
	endtask
endmodule
`default_nettype wire

// ### test/wor_timer_checker.sv
// Purpose: port-level checks of the wake timer
// Assumes: synchronous active-low reset
// Notes: bound into every wor_timer
`timescale 1ns/1ns
`default_nettype none
module wor_timer_checker (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic       rvalid_o,
	input wire logic       rc_osc_run_o,
	input wire logic       calibrating_o,
	input wire logic       first_event_o,
	input wire logic       second_event_o,
	input wire logic [5:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_rd_valid: assert property (rd_i |=> rvalid_o)
		else $error("read without valid");
	a_byte_back: assert property ((wr_i && addr_i[5:1] == 5'h0f) ##2
		(rd_i && addr_i == $past(addr_i, 2)) |=> rdata_o == $past(wdata_i, 3))
		else $error("timeout byte lost");
	a_reset_off: assert property ($rose(rst_n_i) |-> !rc_osc_run_o)
		else $error("osc on after reset");
	a_pd_run: assert property (wr_i && addr_i == 6'h20 |=>
		rc_osc_run_o != $past(wdata_i[7])) else $error("run mismatch");
	a_cal_start: assert property (wr_i && addr_i == 6'h20 && !wdata_i[7] &&
		wdata_i[3] && !rc_osc_run_o |-> ##2 calibrating_o)
		else $error("no calibration");
	a_cal_gate: assert property (wr_i && addr_i == 6'h20 && !wdata_i[3]
		|-> ##2 !calibrating_o) else $error("calibration not gated");
	a_first_gap: assert property (first_event_o |=> !first_event_o [*8])
		else $error("event too soon");
	a_idle_quiet: assert property (!rc_osc_run_o && $past(!rc_osc_run_o)
		|-> !first_event_o) else $error("event while off");
	a_second_quiet: assert property (!rc_osc_run_o && $past(!rc_osc_run_o)
		|-> !second_event_o) else $error("second event while off");
endmodule
bind wor_timer wor_timer_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.wr_i(wr_i), .rd_i(rd_i), .rvalid_o(rvalid_o), .addr_i(addr_i),
	.rc_osc_run_o(rc_osc_run_o), .calibrating_o(calibrating_o),
	.first_event_o(first_event_o), .second_event_o(second_event_o),
	.wdata_i(wdata_i), .rdata_o(rdata_o));
`default_nettype wire

// ### test/wor_timer_tb.sv
// Purpose: register and event timing test of the wake timer
// Assumes: 8 ns clock, one rc tick per 750 clocks
// Notes: event gaps allow two clocks of slack
`timescale 1ns/1ns
`default_nettype none
module wor_timer_tb;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [5:0] addr;
	logic       wr, rd, rvalid, first_ev, second_ev;
	logic       run, cal;
	logic [7:0] wdata, rdata, d;
	int         bad_count = 0;
	int         n_compared = 0;
	int         n;
	always #4 clk_i = ~clk_i;
	wor_host u_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
	wor_timer #(.CAL_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.addr_i(addr), .wr_i(wr), .wdata_i(wdata), .rd_i(rd),
		.rdata_o(rdata), .rvalid_o(rvalid), .rc_osc_run_o(run),
		.calibrating_o(cal), .first_event_o(first_ev),
		.second_event_o(second_ev));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		u_host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic gap(input logic sec, input int e);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while ((sec ? second_ev : first_ev) !== 1'b1 && n < 40000);
		if (e > 0)
			chk((n > e - 3 && n < e + 3) ? e : n, e);
		else
			chk(n < 40000, 1);
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk(6'h1e, 8'h87);
		rchk(6'h1f, 8'h6b);
		rchk(6'h20, 8'hf8);
		u_host.wr(6'h1e, 8'h00);
		rchk(6'h1e, 8'h00);
		u_host.wr(6'h1f, 8'h10);
		rchk(6'h1f, 8'h10);
		u_host.wr(6'h21, 8'h5a);
		rchk(6'h21, 8'h00);
		u_host.wr(6'h20, 8'h3c);
		repeat (2) @(posedge clk_i);
		chk(run, 1'b1);
		chk(cal, 1'b1);
		rchk(6'h20, 8'h38);
		@(posedge clk_i);
		chk(cal, 1'b0);
		gap(1'b0, 0);
		gap(1'b0, 12000);
		gap(1'b1, 9000);
		u_host.wr(6'h20, 8'h08);
		gap(1'b0, 0);
		gap(1'b1, 3000);
		u_host.wr(6'h1f, 8'h01);
		u_host.wr(6'h20, 8'h31);
		rchk(6'h20, 8'h31);
		gap(1'b0, 0);
		gap(1'b0, 24000);
		u_host.wr(6'h20, 8'hb1);
		@(posedge clk_i);
		chk(run, 1'b0);
		rchk(6'h20, 8'hb1);
		test_done;
	end
	// the longest path through the sequence is about 87000 clocks
	initial begin
		repeat (100000) @(posedge clk_i);
		bad_count++;
		test_done;
	end
endmodule
`default_nettype wire
